// ---- sbc_ctrl.v ----
// command-bus controller: checks each request against per-bank state and
// drives chip select, row/column strobes, write enable, bank and address.
// assumes requests from logic on core_clk; mem_clk_in is the device clock pin
`timescale 1ns/1ps
`include "sbc_consts.vh"
module sbc_ctrl
(
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        clk_en,
  input  wire        mem_clk_in,
  input  wire        req_valid,
  input  wire [2:0]  req_op,
  input  wire [1:0]  req_bank,
  input  wire [13:0] req_addr,
  input  wire        req_autoclose,
  input  wire        req_close_all,
  input  wire        burst_len8,
  output wire        req_ready,
  output reg         req_illegal,
  output reg         cmd_issued,
  output reg         cs_n,
  output reg         ras_n,
  output reg         cas_n,
  output reg         we_n,
  output reg  [1:0]  bank_addr,
  output reg  [13:0] mem_addr,
  output wire        all_idle,
  output wire        dev_busy
);
  localparam [7:0] CYC_CLOSE = `SBC_CYC(`SBC_T_CLOSE_NS);
  localparam [7:0] CYC_OPEN  = `SBC_CYC(`SBC_T_OPEN_NS);
  localparam [7:0] CYC_WREC  = `SBC_CYC(`SBC_T_WREC_NS);
  localparam [7:0] CYC_REFR  = `SBC_CYC(`SBC_T_REFR_NS);
  localparam [7:0] CYC_MODE  = `SBC_CYC(`SBC_T_MODE_NS);
  localparam [7:0] CYC_BL4   = `SBC_BL4_CYC;
  localparam [7:0] CYC_BL8   = `SBC_BL8_CYC;

  // device clock pin: three flops, an edge counts when stages 2 and 3 agree
  reg  [2:0] mclk_sync_reg;
  reg        mclk_level_reg;
  wire       mclk_rise;
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      mclk_sync_reg  <= 3'h0;
      mclk_level_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      mclk_sync_reg <= {mclk_sync_reg[1:0], mem_clk_in};
      if (mclk_sync_reg[1] == mclk_sync_reg[2])
        mclk_level_reg <= mclk_sync_reg[2];
    end
  end
  assign mclk_rise = (mclk_sync_reg[1] == mclk_sync_reg[2]) && mclk_sync_reg[2] && !mclk_level_reg;

  // per-bank state and timers
  reg  [3:0] bank_st_reg  [0:3];
  reg  [7:0] bank_cnt_reg [0:3];
  reg  [3:0] bank_st_next [0:3];
  reg  [7:0] bank_cnt_next[0:3];
  // device-wide busy for refresh and mode set
  reg  [7:0] dev_cnt_reg;
  reg  [7:0] dev_cnt_next;
  wire       ok;
  reg        legal;
  reg  [3:0] cur_st;
  reg  [7:0] cur_cnt;
  wire [3:0] idle_vec;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_idle
      assign idle_vec[g] = (bank_st_reg[g] == `SBC_ST_IDLE);
    end
  endgenerate
  assign all_idle  = &idle_vec;
  assign dev_busy  = (dev_cnt_reg != 8'h00);
  // a request waits for the next rising device clock edge, then issues in one cycle
  assign req_ready = mclk_rise && clk_en;
  assign ok        = req_valid && req_ready;

  // legality of the request against the target bank state
  always @*
  begin
    cur_st  = bank_st_reg[req_bank];
    cur_cnt = bank_cnt_reg[req_bank];
    legal   = 1'b0;
    if (dev_busy)
      legal = (req_op == `SBC_OP_NOP);
    else
    begin
      case (req_op)
        `SBC_OP_NOP:
          legal = 1'b1;
        `SBC_OP_OPEN:
          legal = (cur_st == `SBC_ST_IDLE);
        `SBC_OP_READ:
          legal = (cur_st == `SBC_ST_ACTIVE) ||
                  (cur_st == `SBC_ST_READ && burst_len8 && cur_cnt == CYC_BL4);
        `SBC_OP_WRITE:
          legal = (cur_st == `SBC_ST_ACTIVE) || (cur_st == `SBC_ST_WREC) ||
                  (cur_st == `SBC_ST_WRITE && burst_len8 && cur_cnt == CYC_BL4);
        `SBC_OP_CLOSE:
          if (req_close_all)
            legal = 1'b0;                                                // judged below
          else
            legal = (cur_st == `SBC_ST_ACTIVE) || (cur_st == `SBC_ST_IDLE) ||
                    (cur_st == `SBC_ST_CLOSING);
        `SBC_OP_REFRESH, `SBC_OP_MODE, `SBC_OP_SELFREF:
          legal = all_idle;
        default:
          legal = 1'b0;
      endcase
      if (req_close_all && req_op == `SBC_OP_CLOSE)
        legal = (idle_vec | ~{bank_st_reg[3] != `SBC_ST_ACTIVE, bank_st_reg[2] != `SBC_ST_ACTIVE,
                 bank_st_reg[1] != `SBC_ST_ACTIVE, bank_st_reg[0] != `SBC_ST_ACTIVE}) == 4'hf;
    end
  end

  // next state per bank: timers run down, expiry moves on, a legal command starts
  integer b;
  always @*
  begin
    dev_cnt_next = dev_cnt_reg;
    if (dev_cnt_reg != 8'h00)
      dev_cnt_next = dev_cnt_reg - 8'h01;
    for (b = 0; b < 4; b = b + 1)
    begin
      bank_st_next[b]  = bank_st_reg[b];
      bank_cnt_next[b] = bank_cnt_reg[b];
      if (bank_cnt_reg[b] > 8'h01)
        bank_cnt_next[b] = bank_cnt_reg[b] - 8'h01;
      else if (bank_cnt_reg[b] == 8'h01)
      begin
        bank_cnt_next[b] = 8'h00;
        case (bank_st_reg[b])
          `SBC_ST_OPENING:  bank_st_next[b] = `SBC_ST_ACTIVE;
          `SBC_ST_READ:     bank_st_next[b] = `SBC_ST_ACTIVE;
          `SBC_ST_WRITE:
          begin
            bank_st_next[b]  = `SBC_ST_WREC;
            bank_cnt_next[b] = CYC_WREC;
          end
          `SBC_ST_WRITE_AC:
          begin
            bank_st_next[b]  = `SBC_ST_WREC_AC;
            bank_cnt_next[b] = CYC_WREC;
          end
          `SBC_ST_READ_AC, `SBC_ST_WREC_AC:
          begin
            bank_st_next[b]  = `SBC_ST_CLOSING;
            bank_cnt_next[b] = CYC_CLOSE;
          end
          `SBC_ST_WREC:     bank_st_next[b] = `SBC_ST_ACTIVE;
          `SBC_ST_CLOSING:  bank_st_next[b] = `SBC_ST_IDLE;
          default:          bank_st_next[b] = bank_st_reg[b];
        endcase
      end
      // an illegal request leaves every bank as it was
      if (ok && legal && !dev_busy)
      begin
        if (req_op == `SBC_OP_CLOSE && (req_close_all || b == req_bank) &&
            bank_st_reg[b] != `SBC_ST_CLOSING && bank_st_reg[b] != `SBC_ST_IDLE)
        begin
          bank_st_next[b]  = `SBC_ST_CLOSING;
          bank_cnt_next[b] = CYC_CLOSE;
        end
        else if (b == req_bank)
        begin
          case (req_op)
            `SBC_OP_OPEN:
            begin
              bank_st_next[b]  = `SBC_ST_OPENING;
              bank_cnt_next[b] = CYC_OPEN;
            end
            `SBC_OP_READ:
            begin
              bank_st_next[b]  = req_autoclose ? `SBC_ST_READ_AC : `SBC_ST_READ;
              bank_cnt_next[b] = burst_len8 ? CYC_BL8 : CYC_BL4;
            end
            `SBC_OP_WRITE:
            begin
              bank_st_next[b]  = req_autoclose ? `SBC_ST_WRITE_AC : `SBC_ST_WRITE;
              bank_cnt_next[b] = burst_len8 ? CYC_BL8 : CYC_BL4;
            end
            default:
              bank_st_next[b] = bank_st_next[b];
          endcase
        end
      end
    end
    if (ok && legal && !dev_busy)
    begin
      if (req_op == `SBC_OP_REFRESH)
        dev_cnt_next = CYC_REFR;
      else if (req_op == `SBC_OP_MODE)
        dev_cnt_next = CYC_MODE;
    end
  end

  // state registers
  integer r;
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      dev_cnt_reg <= 8'h00;
      for (r = 0; r < 4; r = r + 1)
      begin
        bank_st_reg[r]  <= `SBC_ST_IDLE;
        bank_cnt_reg[r] <= 8'h00;
      end
    end
    else if (clk_en)
    begin
      dev_cnt_reg <= dev_cnt_next;
      for (r = 0; r < 4; r = r + 1)
      begin
        bank_st_reg[r]  <= bank_st_next[r];
        bank_cnt_reg[r] <= bank_cnt_next[r];
      end
    end
  end

  // command pins: deselect unless a legal non-nop request issues this cycle
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      cs_n        <= 1'b1;
      ras_n       <= 1'b1;
      cas_n       <= 1'b1;
      we_n        <= 1'b1;
      bank_addr   <= 2'h0;
      mem_addr    <= 14'h0000;
      req_illegal <= 1'b0;
      cmd_issued  <= 1'b0;
    end
    else if (clk_en)
    begin
      cs_n        <= 1'b1;
      ras_n       <= 1'b1;
      cas_n       <= 1'b1;
      we_n        <= 1'b1;
      req_illegal <= ok && !legal;
      cmd_issued  <= ok && legal;
      if (ok && legal)
      begin
        bank_addr <= req_bank;
        mem_addr  <= req_addr;
        cs_n      <= (req_op == `SBC_OP_NOP) ? 1'b1 : 1'b0;
        case (req_op)
          `SBC_OP_OPEN:    {ras_n, cas_n, we_n} <= 3'h3;
          `SBC_OP_READ:
          begin
            {ras_n, cas_n, we_n} <= 3'h5;
            mem_addr[10] <= req_autoclose;
          end
          `SBC_OP_WRITE:
          begin
            {ras_n, cas_n, we_n} <= 3'h4;
            mem_addr[10] <= req_autoclose;
          end
          `SBC_OP_CLOSE:
          begin
            {ras_n, cas_n, we_n} <= 3'h2;
            mem_addr[10] <= req_close_all;
          end
          `SBC_OP_REFRESH, `SBC_OP_SELFREF:
            {ras_n, cas_n, we_n} <= 3'h1;
          `SBC_OP_MODE:    {ras_n, cas_n, we_n} <= 3'h0;
          default:         {ras_n, cas_n, we_n} <= 3'h7;
        endcase
      end
    end
  end
endmodule

// ---- sbc_consts.vh ----
// constants for the command-bus controller that drives a ddr2-style memory
// assumes a 10 MHz core clock and a 4-bank device on the far side
//
// Overview of operation
// - auto-close burst: only deselect or nop to bank
// - closing bank: nop/deselect/close, idle after close time; the controller refuses close all while any bank is closing
// - opening bank: only nop until column delay
// - write recovery: nop or new write only
// - write recovery with autoclose: nop only
// - refresh: nop only until refresh cycle time
// - mode set: nop only until mode set delay
// - other banks accept commands their state allows
// - refresh and mode set need all banks idle
// - burst interrupt only with burst length 8
// - interrupt same direction on 4-bit boundary
// - never issue unlisted state/command pairs
// - self refresh only from all banks idle
`ifndef SBC_CONSTS_VH
`define SBC_CONSTS_VH
`define SBC_CLK_NS        100
// timing figures in ns, cycle counts rounded up
`define SBC_T_CLOSE_NS    15
`define SBC_T_OPEN_NS     15
`define SBC_T_WREC_NS     15
`define SBC_T_REFR_NS     128
`define SBC_T_MODE_NS     20
`define SBC_CYC(t)        (((t) + `SBC_CLK_NS - 1) / `SBC_CLK_NS)
// burst length in clocks on the command bus (double data rate)
`define SBC_BL4_CYC       2
`define SBC_BL8_CYC       4
// request opcodes
`define SBC_OP_NOP        3'h0
`define SBC_OP_OPEN       3'h1
`define SBC_OP_READ       3'h2
`define SBC_OP_WRITE      3'h3
`define SBC_OP_CLOSE      3'h4
`define SBC_OP_REFRESH    3'h5
`define SBC_OP_MODE       3'h6
`define SBC_OP_SELFREF    3'h7
// bank states
`define SBC_ST_IDLE       4'h0
`define SBC_ST_OPENING    4'h1
`define SBC_ST_ACTIVE     4'h2
`define SBC_ST_READ       4'h3
`define SBC_ST_WRITE      4'h4
`define SBC_ST_READ_AC    4'h5
`define SBC_ST_WRITE_AC   4'h6
`define SBC_ST_WREC       4'h7
`define SBC_ST_WREC_AC    4'h8
`define SBC_ST_CLOSING    4'h9
`endif

// ---- sbc_ctrl_asserts.sv ----
// concurrent checks on the request answers and command pins of sbc_ctrl
// assumes one core_clk domain with rst_n synchronous and active low
`timescale 1ns/1ps
module sbc_ctrl_asserts
(
  input logic        core_clk,
  input logic        rst_n,
  input logic        clk_en,
  input logic        mem_clk_in,
  input logic        req_valid,
  input logic [2:0]  req_op,
  input logic [1:0]  req_bank,
  input logic [13:0] req_addr,
  input logic        req_autoclose,
  input logic        req_close_all,
  input logic        burst_len8,
  input logic        req_ready,
  input logic        req_illegal,
  input logic        cmd_issued,
  input logic        cs_n,
  input logic        ras_n,
  input logic        cas_n,
  input logic        we_n,
  input logic [1:0]  bank_addr,
  input logic [13:0] mem_addr,
  input logic        all_idle,
  input logic        dev_busy
);
  default clocking ck @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  chk_single_answer: assert property (!(cmd_issued && req_illegal))
    else $error("issued and refused together");
  chk_refused_quiet: assert property (req_illegal |-> cs_n)
    else $error("pins driven for a refused request");
  chk_pin_pulse: assert property (!cs_n |=> cs_n)
    else $error("command held longer than one cycle");
  chk_taken_answer: assert property (req_valid && req_ready && clk_en |=> cmd_issued || req_illegal)
    else $error("taken request got no answer");
  chk_pins_cause: assert property (!cs_n |-> cmd_issued)
    else $error("pins driven without an issued request");
  chk_open_code: assert property (cmd_issued && $past(req_op) == 3'h1 |-> {cs_n, ras_n, cas_n, we_n} == 4'h3)
    else $error("open row encoded wrongly");
  chk_nop_silent: assert property (cmd_issued && $past(req_op) == 3'h0 |-> cs_n)
    else $error("no-operation drove the pins");
  chk_global_idle: assert property (!cs_n && !ras_n && !cas_n |-> $past(all_idle))
    else $error("refresh or mode set with a bank busy");
  // self refresh entry shares the refresh pin code but starts no lock, so key on the taken opcode
  chk_refresh_lock: assert property (cmd_issued && $past(req_op) == 3'h5 |-> dev_busy ##[1:3] !dev_busy)
    else $error("refresh lock missing or too long");
endmodule

bind sbc_ctrl sbc_ctrl_asserts chk_u (.core_clk, .rst_n, .clk_en, .mem_clk_in, .req_valid, .req_op, .req_bank,
  .req_addr, .req_autoclose, .req_close_all, .burst_len8, .req_ready, .req_illegal, .cmd_issued, .cs_n, .ras_n,
  .cas_n, .we_n, .bank_addr, .mem_addr, .all_idle, .dev_busy);

// ---- sbc_mem_model.sv ----
// behavioural memory device: decodes the command pins and keeps row state per bank
// assumes pins sampled on core_clk; timing intervals end before the next request
`timescale 1ns/1ps
module sbc_mem_model
(
  input  logic        core_clk,
  input  logic        rst_n,
  input  logic        cs_n,
  input  logic        ras_n,
  input  logic        cas_n,
  input  logic        we_n,
  input  logic [1:0]  bank_addr,
  input  logic [13:0] mem_addr,
  output int          bad_cmds
);
  logic [3:0] row_open;
  logic       bad;

  // only open or closed is tracked: request spacing outlasts every delay
  always @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      row_open <= 4'h0;
      bad_cmds <= 0;
    end
    else if (!cs_n)
    begin
      case ({ras_n, cas_n, we_n})
        3'b011: bad = row_open[bank_addr];
        3'b101, 3'b100: bad = !row_open[bank_addr];
        3'b001, 3'b000: bad = |row_open;
        default: bad = 1'b0;
      endcase
      // a bad command is counted and leaves the bank as it was
      if (bad)
        bad_cmds <= bad_cmds + 1;
      else if ({ras_n, cas_n, we_n} == 3'b011)
        row_open[bank_addr] <= 1'b1;
      else if ({ras_n, cas_n, we_n} == 3'b010 && mem_addr[10])
        row_open <= 4'h0;
      else if (!cas_n && mem_addr[10] || {ras_n, cas_n, we_n} == 3'b010)
        row_open[bank_addr] <= 1'b0;
    end
  end
endmodule

// ---- sbc_ctrl_test.sv ----
// testbench for sbc_ctrl: hand-written request scenarios, device model on the pins
// assumes a 10 MHz core clock and an 800 ns command clock made here
`timescale 1ns/1ps
module sbc_ctrl_test;
  logic        core_clk, rst_n, mem_clk_in, req_valid, req_autoclose, req_close_all, burst_len8;
  logic [2:0]  req_op;
  logic [1:0]  req_bank;
  logic [13:0] req_addr;
  wire         req_ready, req_illegal, cmd_issued, cs_n, ras_n, cas_n, we_n, all_idle, dev_busy;
  wire  [1:0]  bank_addr;
  wire  [13:0] mem_addr;
  int          failures, samples_checked, bad_cmds;
  int          cycles = 0;
  // expected cs, row, column, write-enable levels per opcode
  localparam logic [3:0] PINS [8] = '{4'hf, 4'h3, 4'h5, 4'h4, 4'h2, 4'h1, 4'h0, 4'h1};

  sbc_ctrl dut_u (.core_clk, .rst_n, .clk_en(1'b1), .mem_clk_in, .req_valid, .req_op, .req_bank, .req_addr,
    .req_autoclose, .req_close_all, .burst_len8, .req_ready, .req_illegal, .cmd_issued, .cs_n, .ras_n, .cas_n,
    .we_n, .bank_addr, .mem_addr, .all_idle, .dev_busy);
  sbc_mem_model mem_u (.core_clk, .rst_n, .cs_n, .ras_n, .cas_n, .we_n, .bank_addr, .mem_addr, .bad_cmds);

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // odd start offset puts every command clock edge 13 ns before a core clock rising edge
  initial
  begin
    mem_clk_in = 1'b0;
    #37;
    forever #400 mem_clk_in = ~mem_clk_in;
  end
  // a hang is cut short well above the few hundred cycles the run needs
  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      failures++;
      summarize();
    end
  end

  task automatic summarize();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // one request held until taken, answer judged in the following cycle
  task automatic req(input logic [2:0] op, input logic [1:0] bank, input logic ac, input logic ill);
    int n;
    n = 0;
    req_op = op;
    req_bank = bank;
    req_autoclose = ac;
    req_close_all = ac;
    req_valid = 1'b1;
    while (req_ready !== 1'b1 && n < 20)
    begin
      @(negedge core_clk);
      n++;
    end
    @(negedge core_clk);
    check("illegal", req_illegal, ill);
    check("issued", cmd_issued, !ill);
    check("pins", {cs_n, ras_n, cas_n, we_n}, ill ? 4'hf : PINS[op]);
    if (!ill && op inside {[1:4]})
      check("bank", bank_addr, bank);
    if (!ill && op inside {[2:4]})
      check("close bit", mem_addr[10], ac);
    req_valid = 1'b0;
    @(negedge core_clk);
  endtask

  // every opcode but self refresh, with bank 0 opened for read, write and close
  task automatic t_codes();
    req(3'h0, 2'h0, 1'b0, 1'b0);
    req(3'h1, 2'h0, 1'b0, 1'b0);
    req(3'h2, 2'h0, 1'b0, 1'b0);
    req(3'h3, 2'h0, 1'b0, 1'b0);
    req(3'h4, 2'h0, 1'b0, 1'b0);
    req(3'h5, 2'h0, 1'b0, 1'b0);
    req(3'h6, 2'h0, 1'b0, 1'b0);
  endtask

  // requests that the bank or device state forbids, then close all
  task automatic t_wrong_state();
    req(3'h1, 2'h1, 1'b0, 1'b0);
    req(3'h1, 2'h1, 1'b0, 1'b1);
    req(3'h2, 2'h2, 1'b0, 1'b1);
    req(3'h1, 2'h2, 1'b0, 1'b0);
    req(3'h5, 2'h0, 1'b0, 1'b1);
    req(3'h6, 2'h0, 1'b0, 1'b1);
    req(3'h7, 2'h0, 1'b0, 1'b1);
    req(3'h4, 2'h0, 1'b1, 1'b0);
    check("all idle", all_idle, 1'b1);
  endtask

  // auto-close bursts run out and leave the bank free to reopen
  task automatic t_autoclose();
    req(3'h1, 2'h3, 1'b0, 1'b0);
    req(3'h3, 2'h3, 1'b1, 1'b0);
    req(3'h1, 2'h3, 1'b0, 1'b0);
    burst_len8 = 1'b1;
    req(3'h2, 2'h3, 1'b1, 1'b0);
    repeat (6) @(negedge core_clk);
    check("all idle", all_idle, 1'b1);
    req(3'h7, 2'h0, 1'b0, 1'b0);
  endtask

  initial
  begin
    failures = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_op = 3'h0;
    req_bank = 2'h0;
    req_addr = 14'h0123;
    req_autoclose = 1'b0;
    req_close_all = 1'b0;
    burst_len8 = 1'b0;
    repeat (12) @(negedge core_clk);
    rst_n = 1'b1;
    t_codes();
    t_wrong_state();
    t_autoclose();
    check("device model errors", bad_cmds, 16'h0);
    summarize();
  end
endmodule
